// ===== design/qrf_regs.sv
/*
 * qrf_regs: formats one converted event into header, datum and
 * end-of-event words in fixed channel order, holds them in a word
 * buffer read over the register port, and keeps the control
 * registers. Assumes a decoded register port: one-cycle rd/wr
 * strobes with a byte offset, read data valid the cycle after rd.
 * An event arrives as a one-cycle strobe with all 32 conversions.
 */
// Contract
// R01: header: type 010, crate, stored count
// R02: datum: type 000, channel, range bit
// R03: under-threshold bit, stored when suppression off
// R04: overflow bit 12, value bits 11..0
// R05: end word: type 100, 24-bit counter
// R06: type 110 marks not-valid word
// R07: empty buffer read returns not-valid word
// R08: order n hi, n+8 hi, n lo, n+8 lo
// R09: skip overflow, under-threshold, disabled channels
// R10: read-only firmware revision register
// R11: slot code resets all ones, tags words
// R12: master writes slot code before chain readout
// R13: slot code in bits 31..27 except not-valid
// R14: chain address register resets to AA
// R15: set register writes ones, reads state
// R16: clear register clears ones; 8 clears error
// R17: bit 3 records bus error, software-settable
// R18: bit 4 picks base address source
// R19: soft reset bit holds module in reset
// R20: hard reset clears all; soft clears bit 3
// R21: interrupt level 3 bits, zero disables
// R22: vector driven during interrupt acknowledge
// R23: buffer words read at 0x0000..0x07FC
// R24: undefined control bits read zero
`timescale 1ns/100ps
`default_nettype none
module qrf_regs #(
	parameter int DEPTH = 512,
	parameter logic [15:0] FW_REV = 16'h0100 // arbitrary value
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [15:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_wdata,
	output logic [31:0] reg_rdata,
	input wire logic iack,
	input wire logic bus_error_event,
	input wire logic evt_valid,
	input wire logic [7:0] evt_crate,
	input wire logic [23:0] evt_count,
	input wire logic [31:0] evt_ovf,
	input wire logic [31:0] evt_under,
	input wire logic [31:0] evt_disable,
	input wire logic evt_suppress_off,
	input wire logic [383:0] evt_value,
	output logic evt_busy,
	output logic soft_reset,
	output logic addr_sel_internal,
	output logic [7:0] chain_address,
	output logic [2:0] irq_level,
	output logic irq_enabled,
	output logic buf_empty
);
	import qrf_pkg::*;

	localparam int AW = $clog2(DEPTH);
	if (DEPTH < 64 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
		$error("DEPTH must be a power of two, at least 64");
	end

	typedef enum logic [1:0] {QRF_IDLE, QRF_HEAD, QRF_DATA, QRF_END} qrf_state_t;

	// ==========================================================
	// control registers
	logic [4:0] slot_ff;
	logic [7:0] chain_ff;
	logic [7:0] set1_ff;
	logic [2:0] lvl_ff;
	logic [7:0] vec_ff;
	logic wr_slot, wr_chain, wr_set, wr_clr, wr_lvl, wr_vec;

	assign wr_slot = reg_wr && reg_addr == OFF_SLOT;
	assign wr_chain = reg_wr && reg_addr == OFF_CHAIN;
	assign wr_set = reg_wr && reg_addr == OFF_SET1;
	assign wr_clr = reg_wr && reg_addr == OFF_CLR1;
	assign wr_lvl = reg_wr && reg_addr == OFF_IRQ_LVL;
	assign wr_vec = reg_wr && reg_addr == OFF_IRQ_VEC;

	// slot code and chain address survive soft reset
	always_ff @(posedge clk) begin
		if (!resetn) begin
			slot_ff <= RST_SLOT; // R11
			chain_ff <= RST_CHAIN; // R14
		end else begin
			if (wr_slot)
				slot_ff <= reg_wdata[4:0]; // R11
			if (wr_chain)
				chain_ff <= reg_wdata[7:0];
		end
	end

	// set/clear pair; a hardware error event wins over a clear
	logic [7:0] nxt_set1;
	always_comb begin
		nxt_set1 = set1_ff;
		if (wr_set)
			nxt_set1 = nxt_set1 | reg_wdata[7:0]; // R15
		if (wr_clr)
			nxt_set1 = nxt_set1 & ~reg_wdata[7:0]; // R16
		if (set1_ff[BIT_SOFT_RST] && !wr_clr)
			nxt_set1[BIT_BERR] = 1'b0; // R20
		if (bus_error_event)
			nxt_set1[BIT_BERR] = 1'b1; // R17
		nxt_set1[2:0] = 3'h0; // R24
		nxt_set1[6:5] = 2'h0;
	end

	always_ff @(posedge clk) begin
		if (!resetn)
			set1_ff <= {3'h0, RST_SET1}; // R20
		else
			set1_ff <= nxt_set1; // R19
	end

	// interrupt level and vector; only hardware reset clears them
	always_ff @(posedge clk) begin
		if (!resetn) begin
			lvl_ff <= RST_IRQ_LVL;
			vec_ff <= RST_IRQ_VEC;
		end else begin
			if (wr_lvl)
				lvl_ff <= reg_wdata[2:0]; // R21
			if (wr_vec)
				vec_ff <= reg_wdata[7:0];
		end
	end

	// ==========================================================
	// event formatter: 32 slots walk n hi, n+8 hi, n lo, n+8 lo
	qrf_state_t st_ff;
	logic [4:0] idx_ff;
	logic [5:0] cnt_ff;
	logic [31:0] keep_ff;
	logic [383:0] val_ff;
	logic [31:0] ovf_ff;
	logic [31:0] und_ff;
	logic [7:0] crate_ff;
	logic [23:0] evcnt_ff;
	logic [31:0] keep;
	logic [4:0] slot_id;
	logic [3:0] chan;
	logic rng;
	logic [11:0] val;
	logic [31:0] wr_word;
	logic wr_en;
	logic buf_full;

	// store set: drop disabled, overflow, suppressed under-threshold
	genvar g;
	generate
		for (g = 0; g < 32; g++) begin : g_keep
			assign keep[g] = !evt_disable[g] && !evt_ovf[g] &&
				(!evt_under[g] || evt_suppress_off); // R09 R03
		end
	endgenerate

	// slot index i: n = i[4:2], upper half by i[0], low range by i[1]
	assign slot_id = idx_ff;
	assign chan = {slot_id[0], slot_id[4:2]}; // R08
	assign rng = slot_id[1]; // R02
	assign val = val_ff[{rng, chan} * 12 +: 12];

	// count of stored channels known before the header goes out
	function automatic logic [5:0] qrf_popcount(input logic [31:0] v);
		logic [5:0] c;
		c = 6'h0;
		for (int i = 0; i < 32; i++)
			c = c + {5'h0, v[i]};
		return c;
	endfunction

	always_ff @(posedge clk) begin
		if (!resetn || soft_reset) begin
			st_ff <= QRF_IDLE;
			idx_ff <= 5'h0;
			cnt_ff <= 6'h0;
			keep_ff <= 32'h0;
			val_ff <= '0;
			ovf_ff <= 32'h0;
			und_ff <= 32'h0;
			crate_ff <= 8'h0;
			evcnt_ff <= 24'h0;
		end else begin
			case (st_ff)
				QRF_IDLE: begin
					if (evt_valid) begin
						keep_ff <= keep;
						cnt_ff <= qrf_popcount(keep);
						val_ff <= evt_value;
						ovf_ff <= evt_ovf;
						und_ff <= evt_under;
						crate_ff <= evt_crate;
						evcnt_ff <= evt_count;
						idx_ff <= 5'h0;
						st_ff <= QRF_HEAD;
					end
				end
				QRF_HEAD: begin
					if (!buf_full)
						st_ff <= QRF_DATA;
				end
				QRF_DATA: begin
					if (!buf_full || !keep_ff[{rng, chan}]) begin
						idx_ff <= idx_ff + 5'h1;
						if (idx_ff == 5'h1F)
							st_ff <= QRF_END;
					end
				end
				QRF_END: begin
					if (!buf_full)
						st_ff <= QRF_IDLE;
				end
				default: st_ff <= QRF_IDLE;
			endcase
		end
	end

	// word assembly per state
	always_comb begin
		wr_en = 1'b0;
		wr_word = 32'h0;
		case (st_ff)
			QRF_HEAD: begin
				wr_en = 1'b1;
				wr_word[31:POS_SLOT] = slot_ff; // R13
				wr_word[26:POS_TYPE] = TYPE_HEADER; // R01
				wr_word[23:POS_CRATE] = crate_ff;
				wr_word[13:POS_CNT] = cnt_ff;
			end
			QRF_DATA: begin
				wr_en = keep_ff[{rng, chan}];
				wr_word[31:POS_SLOT] = slot_ff;
				wr_word[26:POS_TYPE] = TYPE_DATUM; // R02
				wr_word[20:POS_CHAN] = chan;
				wr_word[POS_RANGE] = rng;
				wr_word[POS_UNDER] = und_ff[{rng, chan}]; // R03
				wr_word[POS_OVF] = ovf_ff[{rng, chan}]; // R04
				wr_word[11:0] = val;
			end
			QRF_END: begin
				wr_en = 1'b1;
				wr_word[31:POS_SLOT] = slot_ff;
				wr_word[26:POS_TYPE] = TYPE_EOE; // R05
				wr_word[23:0] = evcnt_ff;
			end
			default: wr_en = 1'b0;
		endcase
	end

	// ==========================================================
	// word buffer; reads pop, so any word-aligned address in the window drains it
	logic [31:0] mem [DEPTH];
	logic [AW:0] wp_ff, rp_ff;
	logic rd_buf, push;

	assign buf_full = (wp_ff - rp_ff) == (AW+1)'(DEPTH);
	assign push = wr_en && !buf_full;
	assign rd_buf = reg_rd && reg_addr <= OFF_BUF_LAST &&
		reg_addr[1:0] == 2'h0; // R23

	always_ff @(posedge clk) begin
		if (push)
			mem[wp_ff[AW-1:0]] <= wr_word;
	end

	always_ff @(posedge clk) begin
		if (!resetn || soft_reset) begin
			wp_ff <= '0;
			rp_ff <= '0;
		end else begin
			if (push)
				wp_ff <= wp_ff + 1'b1;
			if (rd_buf && wp_ff != rp_ff)
				rp_ff <= rp_ff + 1'b1;
		end
	end

	// ==========================================================
	// read mux; interrupt acknowledge takes the bus first
	always_ff @(posedge clk) begin
		if (!resetn) begin
			reg_rdata <= 32'h0;
		end else if (iack) begin
			reg_rdata <= {24'h0, vec_ff}; // R22
		end else if (rd_buf) begin
			if (wp_ff == rp_ff)
				reg_rdata <= WORD_INVALID; // R07 R06
			else
				reg_rdata <= mem[rp_ff[AW-1:0]];
		end else if (reg_rd) begin
			case (reg_addr)
				OFF_FW_REV: reg_rdata <= {16'h0, FW_REV}; // R10
				OFF_SLOT: reg_rdata <= {27'h0, slot_ff};
				OFF_CHAIN: reg_rdata <= {24'h0, chain_ff};
				OFF_SET1, OFF_CLR1: reg_rdata <= {24'h0, set1_ff}; // R15
				OFF_IRQ_LVL: reg_rdata <= {29'h0, lvl_ff}; // R24
				OFF_IRQ_VEC: reg_rdata <= {24'h0, vec_ff};
				default: reg_rdata <= 32'h0;
			endcase
		end
	end

	// ==========================================================
	// registered status outputs
	always_ff @(posedge clk) begin
		if (!resetn) begin
			soft_reset <= 1'b0;
			addr_sel_internal <= 1'b0;
			chain_address <= RST_CHAIN;
			irq_level <= RST_IRQ_LVL;
			irq_enabled <= 1'b0;
			buf_empty <= 1'b1;
			evt_busy <= 1'b0;
		end else begin
			soft_reset <= nxt_set1[BIT_SOFT_RST]; // R19
			addr_sel_internal <= nxt_set1[BIT_SEL_ADDR]; // R18
			chain_address <= chain_ff;
			irq_level <= lvl_ff;
			irq_enabled <= lvl_ff != 3'h0; // R21
			buf_empty <= wp_ff == rp_ff;
			evt_busy <= st_ff != QRF_IDLE || evt_valid;
		end
	end

	// ==========================================================
	// checks
	property p_empty_invalid;
		@(posedge clk) disable iff (!resetn)
		(rd_buf && !iack && wp_ff == rp_ff) |=> reg_rdata == WORD_INVALID;
	endproperty
	a_empty_invalid: assert property (p_empty_invalid) // R07
		else $error("empty read not invalid");
	property p_set_bit;
		@(posedge clk) disable iff (!resetn)
		(wr_set && reg_wdata[BIT_SEL_ADDR]) |=> set1_ff[BIT_SEL_ADDR];
	endproperty
	a_set_bit: assert property (p_set_bit) // R15
		else $error("set write lost");
	property p_clr_bit;
		@(posedge clk) disable iff (!resetn)
		(wr_clr && reg_wdata[BIT_SEL_ADDR]) |=> !set1_ff[BIT_SEL_ADDR];
	endproperty
	a_clr_bit: assert property (p_clr_bit) // R16
		else $error("clear write lost");
	property p_berr;
		@(posedge clk) disable iff (!resetn)
		bus_error_event |=> set1_ff[BIT_BERR];
	endproperty
	a_berr: assert property (p_berr) // R17
		else $error("bus error not recorded");
	property p_soft_hold;
		@(posedge clk) disable iff (!resetn)
		(set1_ff[BIT_SOFT_RST] && !wr_clr) |=>
			set1_ff[BIT_SOFT_RST] && soft_reset;
	endproperty
	a_soft_hold: assert property (p_soft_hold) // R19
		else $error("soft reset dropped");
	property p_header;
		@(posedge clk) disable iff (!resetn)
		(st_ff == QRF_HEAD) |-> wr_word[26:24] == 3'h2 &&
			wr_word[31:27] == slot_ff &&
			wr_word[13:8] == 6'($countones(keep_ff));
	endproperty
	a_header: assert property (p_header) // R01
		else $error("bad header word");
	property p_end;
		@(posedge clk) disable iff (!resetn)
		(st_ff == QRF_END) |-> wr_word[26:24] == 3'h4 &&
			wr_word[23:0] == evcnt_ff;
	endproperty
	a_end: assert property (p_end) // R05
		else $error("bad end word");
	property p_lvl;
		@(posedge clk) disable iff (!resetn)
		wr_lvl |=> ##1 irq_level == $past(reg_wdata[2:0], 2) &&
			irq_enabled == ($past(reg_wdata[2:0], 2) != 3'h0);
	endproperty
	a_lvl: assert property (p_lvl) // R21
		else $error("level mismatch");
	property p_iack;
		@(posedge clk) disable iff (!resetn)
		iack |=> reg_rdata == {24'h0, $past(vec_ff)};
	endproperty
	a_iack: assert property (p_iack) // R22
		else $error("vector not driven");
endmodule
`default_nettype wire

// ===== pkg/qrf_pkg.sv
/*
 * qrf_pkg: register offsets, field positions, reset values and word
 * type codes for the readout formatter and control register bank.
 * Assumes a 16-bit register address and 32-bit data path.
 */
`default_nettype none
package qrf_pkg;
	// ==========================================================
	// register offsets
	localparam logic [15:0] OFF_BUF_LAST = 16'h07FC;
	localparam logic [15:0] OFF_FW_REV = 16'h1000;
	localparam logic [15:0] OFF_SLOT = 16'h1002;
	localparam logic [15:0] OFF_CHAIN = 16'h1004;
	localparam logic [15:0] OFF_SET1 = 16'h1006;
	localparam logic [15:0] OFF_CLR1 = 16'h1008;
	localparam logic [15:0] OFF_IRQ_LVL = 16'h100A;
	localparam logic [15:0] OFF_IRQ_VEC = 16'h100C;
	// ==========================================================
	// reset values
	localparam logic [4:0] RST_SLOT = 5'h1F;
	localparam logic [7:0] RST_CHAIN = 8'hAA;
	localparam logic [2:0] RST_IRQ_LVL = 3'h0;
	localparam logic [7:0] RST_IRQ_VEC = 8'h00;
	localparam logic [4:0] RST_SET1 = 5'h00;
	// ==========================================================
	// set register bit positions
	localparam int BIT_BERR = 3;
	localparam int BIT_SEL_ADDR = 4;
	localparam int BIT_SOFT_RST = 7;
	// ==========================================================
	// buffer word fields
	localparam int POS_SLOT = 27;
	localparam int POS_TYPE = 24;
	localparam int POS_CRATE = 16;
	localparam int POS_CNT = 8;
	localparam int POS_CHAN = 17;
	localparam int POS_RANGE = 16;
	localparam int POS_UNDER = 13;
	localparam int POS_OVF = 12;
	localparam logic [2:0] TYPE_HEADER = 3'h2;
	localparam logic [2:0] TYPE_DATUM = 3'h0;
	localparam logic [2:0] TYPE_EOE = 3'h4;
	localparam logic [2:0] TYPE_INVALID = 3'h6;
	localparam logic [31:0] WORD_INVALID = 32'h06000000;
endpackage
`default_nettype wire

// ===== tb/qrf_master.sv
/*
 * qrf_master: bus master model on the register port. It programs the
 * control registers and reads event words for the bench.
 * Assumes one-cycle strobes and read data one cycle after a strobe.
 */
`timescale 1ns/100ps
`default_nettype none
module qrf_master (
	input wire logic clk,
	output logic [15:0] reg_addr,
	output logic reg_wr,
	output logic reg_rd,
	output logic [15:0] reg_wdata,
	output logic iack,
	input wire logic [31:0] reg_rdata
);
	// ============================================================
	// idle levels, so nothing is requested before reset ends
	initial begin
		reg_addr = 16'h0000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_wdata = 16'h0000;
		iack = 1'b0;
	end
	// ============================================================
	// bus cycles: strobe one edge, drop it next edge
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	// data is taken one edge after the strobe was seen
	task automatic rd(input logic [15:0] a, output logic [31:0] v);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(posedge clk);
		v = reg_rdata;
	endtask
	task automatic ack(output logic [31:0] v);
		@(posedge clk);
		iack <= 1'b1;
		@(posedge clk);
		iack <= 1'b0;
		@(posedge clk);
		v = reg_rdata;
	endtask
endmodule
`default_nettype wire

// ===== tb/tb_qdc_readout_format_and_control_regs.sv
/*
 * tb_qdc_readout_format_and_control_regs: self-checking bench for
 * the formatter and control registers. Assumes the bus master model
 * in qrf_master and the constants of qrf_pkg.
 */
`timescale 1ns/100ps
`default_nettype none
module tb_qdc_readout_format_and_control_regs;
	import qrf_pkg::*;
	localparam logic [15:0] FW = 16'h0203; // arbitrary revision value
	localparam logic [4:0] SLOT = 5'h15;
	localparam logic [7:0] CRATE = 8'h3C;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic [15:0] reg_addr, reg_wdata;
	logic reg_wr, reg_rd, iack, bus_error_event = 1'b0;
	logic [31:0] reg_rdata, v;
	logic evt_valid = 1'b0, evt_suppress_off = 1'b0;
	logic [7:0] evt_crate = CRATE;
	logic [23:0] evt_count = 24'h0;
	logic [31:0] evt_ovf = 32'h0, evt_under = 32'h0, evt_disable = 32'h0;
	logic [383:0] evt_value;
	logic evt_busy, soft_reset, addr_sel_internal, irq_enabled, buf_empty;
	logic [7:0] chain_address;
	logic [2:0] irq_level;
	logic [31:0] exp_q[$];
	int fails = 0;
	int compares = 0;
	always #2 clk = ~clk;
	qrf_regs #(.DEPTH(512), .FW_REV(FW)) u_qrf_regs (.clk(clk),
		.resetn(resetn), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.iack(iack), .bus_error_event(bus_error_event),
		.evt_valid(evt_valid), .evt_crate(evt_crate),
		.evt_count(evt_count), .evt_ovf(evt_ovf), .evt_under(evt_under),
		.evt_disable(evt_disable), .evt_suppress_off(evt_suppress_off),
		.evt_value(evt_value), .evt_busy(evt_busy),
		.soft_reset(soft_reset), .addr_sel_internal(addr_sel_internal),
		.chain_address(chain_address), .irq_level(irq_level),
		.irq_enabled(irq_enabled), .buf_empty(buf_empty));
	qrf_master u_qrf_master (.clk(clk), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
		.iack(iack), .reg_rdata(reg_rdata));
	// ============================================================
	// compare and closing tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("FAIL %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic rc(input logic [15:0] a, input logic [31:0] exp);
		u_qrf_master.rd(a, v);
		chk(v, exp);
	endtask
	task automatic test_done;
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// ============================================================
	// one event: expected words built from masks, then strobed in
	task automatic send_evt(input logic [31:0] ovf, input logic [31:0] und,
		input logic [31:0] dis, input logic sup, input logic [23:0] cnt);
		logic [31:0] d[$];
		logic [4:0] s;
		int n;
		for (int i = 0; i < 32; i++) begin
			s = {i[1], i[0], i[4:2]};
			if (!ovf[s] && !dis[s] && (!und[s] || sup))
				d.push_back({SLOT, TYPE_DATUM, 3'h0, s[3:0], s[4], 2'h0,
					und[s], 1'b0, 12'h100 + 12'(s)});
		end
		exp_q.push_back({SLOT, TYPE_HEADER, CRATE, 2'h0, 6'(d.size()), 8'h00});
		foreach (d[k])
			exp_q.push_back(d[k]);
		exp_q.push_back({SLOT, TYPE_EOE, cnt});
		@(posedge clk);
		evt_ovf <= ovf;
		evt_under <= und;
		evt_disable <= dis;
		evt_suppress_off <= sup;
		evt_count <= cnt;
		evt_valid <= 1'b1;
		@(posedge clk);
		evt_valid <= 1'b0;
		#1;
		chk(32'(evt_busy), 32'h1);
		// bounded wait for the formatter to finish
		for (n = 0; n < 200 && evt_busy !== 1'b0; n++) begin
			@(posedge clk);
			#1;
		end
		chk(32'(n < 200), 32'h1);
	endtask
	// ============================================================
	// watchdog: the tests need well under 3000 cycles
	initial begin
		repeat (20000) @(posedge clk);
		fails++;
		test_done;
	end
	// ============================================================
	// main sequence
	initial begin
		for (int s = 0; s < 32; s++)
			evt_value[s * 12 +: 12] = 12'h100 + 12'(s);
		repeat (3) @(posedge clk);
		resetn <= 1'b1;
		rc(OFF_FW_REV, {16'h0, FW});
		rc(OFF_SLOT, 32'h1F);
		rc(OFF_CHAIN, 32'hAA);
		rc(OFF_SET1, 32'h0);
		rc(OFF_IRQ_LVL, 32'h0);
		rc(OFF_IRQ_VEC, 32'h0);
		rc(16'h0000, WORD_INVALID);
		u_qrf_master.wr(OFF_FW_REV, 16'hFFFF);
		rc(OFF_FW_REV, {16'h0, FW});
		u_qrf_master.wr(16'h1010, 16'hFFFF);
		rc(16'h1010, 32'h0);
		$display("test reset values done");
		u_qrf_master.wr(OFF_SLOT, 16'hFFF5);
		rc(OFF_SLOT, 32'h15);
		u_qrf_master.wr(OFF_CHAIN, 16'h1233);
		rc(OFF_CHAIN, 32'h33);
		chk(32'(chain_address), 32'h33);
		u_qrf_master.wr(OFF_IRQ_LVL, 16'h000D);
		rc(OFF_IRQ_LVL, 32'h5);
		chk(32'({irq_enabled, irq_level}), 32'hD);
		u_qrf_master.wr(OFF_IRQ_LVL, 16'h0000);
		rc(OFF_IRQ_LVL, 32'h0);
		chk(32'(irq_enabled), 32'h0);
		u_qrf_master.wr(OFF_IRQ_VEC, 16'h01A5);
		rc(OFF_IRQ_VEC, 32'hA5);
		u_qrf_master.ack(v);
		chk(v, 32'hA5);
		$display("test plain registers done");
		u_qrf_master.wr(OFF_SET1, 16'h0010);
		rc(OFF_SET1, 32'h10);
		chk(32'(addr_sel_internal), 32'h1);
		u_qrf_master.wr(OFF_SET1, 16'h0007);
		rc(OFF_SET1, 32'h10);
		@(posedge clk);
		bus_error_event <= 1'b1;
		@(posedge clk);
		bus_error_event <= 1'b0;
		rc(OFF_SET1, 32'h18);
		u_qrf_master.wr(OFF_CLR1, 16'h0008);
		rc(OFF_SET1, 32'h10);
		// clear the address-source bit, then restore it for later tests
		u_qrf_master.wr(OFF_CLR1, 16'h0010);
		rc(OFF_SET1, 32'h0);
		chk(32'(addr_sel_internal), 32'h0);
		u_qrf_master.wr(OFF_SET1, 16'h0010);
		u_qrf_master.wr(OFF_SET1, 16'h0008);
		rc(OFF_CLR1, 32'h18);
		$display("test set and clear done");
		send_evt(32'h3, 32'h0001_0100, 32'h8000_0000, 1'b0, 24'h00ABCD);
		send_evt(32'h0, 32'hF000_000F, 32'h0, 1'b1, 24'hFFFFFE);
		chk(32'(buf_empty), 32'h0);
		// alternate the two ends of the window: every read pops a word
		foreach (exp_q[k])
			rc(k[0] ? OFF_BUF_LAST : 16'h0000, exp_q[k]);
		rc(16'h0400, WORD_INVALID);
		chk(32'(buf_empty), 32'h1);
		$display("test event words done");
		send_evt(32'h0, 32'h0, 32'h0, 1'b0, 24'h1);
		u_qrf_master.wr(OFF_SET1, 16'h0080);
		rc(OFF_SET1, 32'h90);
		chk(32'(soft_reset), 32'h1);
		rc(OFF_SLOT, 32'h15);
		u_qrf_master.wr(OFF_CLR1, 16'h0080);
		rc(OFF_SET1, 32'h10);
		chk(32'(soft_reset), 32'h0);
		rc(16'h0000, WORD_INVALID);
		@(posedge clk);
		resetn <= 1'b0;
		@(posedge clk);
		resetn <= 1'b1;
		rc(OFF_SET1, 32'h0);
		rc(OFF_CHAIN, 32'hAA);
		$display("test resets done");
		test_done;
	end
endmodule
`default_nettype wire
